// [include/gpb_pkg.sv]
package gpb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Printed offsets are indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IOCTL_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] BIAS_IDX = 8'h04;
  localparam logic [ADDR_W-1:0] MISC_IDX = 8'h10;
  localparam logic [REG_W-1:0] IOCTL_RST = 16'h0000;
  localparam logic [REG_W-1:0] BIAS_RST = 16'h0000;
  localparam logic [REG_W-1:0] MISC_RST = 16'h0000;
  localparam logic [REG_W-1:0] IOCTL_MASK = 16'h07ff;
  localparam logic [REG_W-1:0] BIAS_MASK = 16'hcc30;
  localparam logic [REG_W-1:0] MISC_MASK = 16'h0001;
  localparam int BIAS_IN2 = 4;
  localparam int BIAS_IN3 = 5;
  localparam int BIAS_IN4 = 10;
  localparam int BIAS_IN5 = 11;
  localparam int BIAS_IN6 = 14;
  localparam int BIAS_IN7 = 15;
  localparam int MISC_STBY = 0;
  localparam logic [1:0] INT_SEL_PIN0 = 2'b10;
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic sync_clear;
    logic [1:0] int_pin_sel;
    logic pin2_out_value;
    logic pin1_out_value;
    logic pin0_out_value;
    logic rsvd_4;
    logic pin2_direction;
    logic pin1_direction;
    logic pin0_direction;
    logic rsvd_0;
  } gpb_ioctl_s;
  typedef struct packed {
    logic [2:0] oe;
    logic [2:0] out;
  } gpb_pins_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } gpb_bus_e;
endpackage

// [logic/gpb_pin_ctrl.sv]
`timescale 1ns/1ps
module gpb_pin_ctrl (
  input wire logic mclk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic [gpb_pkg::ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [gpb_pkg::DATA_W-1:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [gpb_pkg::DATA_W-1:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic standby_state, // Standby status from core logic
  input wire logic irq_signal, // Data ready or buffer interrupt
  output gpb_pkg::gpb_pins_s pins, // Pin drive and enables, bit n is pin n
  output logic [5:0] bias_voltage // Bias enables, bit 0 is input two
);
  ////////////////////////////////////////////////////////////////////////////
  gpb_pkg::gpb_bus_e state, next_state;
  gpb_pkg::gpb_ioctl_s ioctl, next_ioctl;
  logic [gpb_pkg::REG_W-1:0] bias, next_bias;
  logic [gpb_pkg::REG_W-1:0] misc, next_misc;
  logic [gpb_pkg::DATA_W-1:0] next_readdata;
  logic next_waitrequest;
  gpb_pkg::gpb_pins_s next_pins;
  logic [5:0] next_bias_voltage;
  logic req, commit;
  logic [gpb_pkg::REG_W-1:0] lane_mask, wdata;
  logic hit_io, hit_bias, hit_misc;

  assign req = avs_read | avs_write;
  assign commit = avs_write & ~avs_waitrequest;
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata[gpb_pkg::REG_W-1:0];
  assign hit_io = avs_address == {gpb_pkg::IOCTL_IDX[gpb_pkg::ADDR_W-3:0], 2'b00};
  assign hit_bias = avs_address == {gpb_pkg::BIAS_IDX[gpb_pkg::ADDR_W-3:0], 2'b00};
  assign hit_misc = avs_address == {gpb_pkg::MISC_IDX[gpb_pkg::ADDR_W-3:0], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer stands for one cycle.
  always_comb begin
    next_state = state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (state)
      gpb_pkg::ST_IDLE: begin
        if (req) begin
          next_state = gpb_pkg::ST_ACK;
          next_waitrequest = 1'b0;
          next_readdata = '0;
          if (hit_io) begin
            next_readdata[gpb_pkg::REG_W-1:0] = ioctl & gpb_pkg::IOCTL_MASK;
          end else if (hit_bias) begin
            next_readdata[gpb_pkg::REG_W-1:0] = bias & gpb_pkg::BIAS_MASK;
          end else if (hit_misc) begin
            next_readdata[gpb_pkg::REG_W-1:0] = misc & gpb_pkg::MISC_MASK;
          end
        end
      end
      gpb_pkg::ST_ACK: begin
        next_state = gpb_pkg::ST_IDLE;
      end
      default: begin
        next_state = gpb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= gpb_pkg::ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      state <= next_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: a write lands at the edge where waitrequest is seen low.
  always_comb begin
    next_ioctl = ioctl;
    next_bias = bias;
    next_misc = misc;
    if (commit && hit_io) begin
      next_ioctl = ((ioctl & ~lane_mask) | (wdata & lane_mask)) & gpb_pkg::IOCTL_MASK;
    end
    if (commit && hit_bias) begin
      // Reserved positions never store, so they always read zero.
      next_bias = ((bias & ~lane_mask) | (wdata & lane_mask)) & gpb_pkg::BIAS_MASK;
    end
    if (commit && hit_misc) begin
      next_misc = ((misc & ~lane_mask) | (wdata & lane_mask)) & gpb_pkg::MISC_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ioctl <= gpb_pkg::IOCTL_RST;
      bias <= gpb_pkg::BIAS_RST;
      misc <= gpb_pkg::MISC_RST;
    end else begin
      ioctl <= next_ioctl;
      bias <= next_bias;
      misc <= next_misc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. Overrides are tested first so that they win over direction.
  always_comb begin
    next_pins = '0;
    if (misc[gpb_pkg::MISC_STBY]) begin
      next_pins.oe[2] = 1'b1;
      next_pins.out[2] = standby_state;
    end else if (ioctl.pin2_direction) begin
      next_pins.oe[2] = 1'b1;
      next_pins.out[2] = ioctl.pin2_out_value;
    end
    if (ioctl.pin1_direction) begin
      next_pins.oe[1] = 1'b1;
      next_pins.out[1] = ioctl.pin1_out_value;
    end
    if (ioctl.int_pin_sel == gpb_pkg::INT_SEL_PIN0) begin
      next_pins.oe[0] = 1'b1;
      next_pins.out[0] = irq_signal;
    end else if (ioctl.pin0_direction) begin
      next_pins.oe[0] = 1'b1;
      next_pins.out[0] = ioctl.pin0_out_value;
    end
    next_bias_voltage = {bias[gpb_pkg::BIAS_IN7], bias[gpb_pkg::BIAS_IN6],
                         bias[gpb_pkg::BIAS_IN5], bias[gpb_pkg::BIAS_IN4],
                         bias[gpb_pkg::BIAS_IN3], bias[gpb_pkg::BIAS_IN2]};
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins <= '0;
      bias_voltage <= '0;
    end else begin
      pins <= next_pins;
      bias_voltage <= next_bias_voltage;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_P2_OUT: assert property (
    !misc[gpb_pkg::MISC_STBY] && ioctl.pin2_direction
    |=> pins.oe[2] && pins.out[2] == $past(ioctl.pin2_out_value))
    else $error("Pin two does not follow its output value.");

  AST_P1_OUT: assert property (
    ioctl.pin1_direction |=> pins.oe[1] && pins.out[1] == $past(ioctl.pin1_out_value))
    else $error("Pin one does not follow its output value.");

  AST_P0_OUT: assert property (
    ioctl.int_pin_sel != gpb_pkg::INT_SEL_PIN0 && ioctl.pin0_direction
    |=> pins.oe[0] && pins.out[0] == $past(ioctl.pin0_out_value))
    else $error("Pin zero does not follow its output value.");

  AST_P2_INPUT: assert property (
    !misc[gpb_pkg::MISC_STBY] && !ioctl.pin2_direction |=> !pins.oe[2])
    else $error("Pin two driven while set to input.");

  AST_STBY: assert property (
    misc[gpb_pkg::MISC_STBY] |=> pins.oe[2] && pins.out[2] == $past(standby_state))
    else $error("Standby indicator not shown on pin two.");

  AST_P1_INPUT: assert property (
    !ioctl.pin1_direction |=> !pins.oe[1] && !pins.out[1])
    else $error("Pin one driven while set to input.");

  AST_IRQ_P0: assert property (
    ioctl.int_pin_sel == gpb_pkg::INT_SEL_PIN0
    |=> pins.oe[0] && pins.out[0] == $past(irq_signal))
    else $error("Interrupt not routed to pin zero.");

  AST_P0_IDLE: assert property (
    ioctl.int_pin_sel != gpb_pkg::INT_SEL_PIN0 && !ioctl.pin0_direction |=> !pins.oe[0])
    else $error("Pin zero driven with no function selected.");

  AST_BIAS_MAP: assert property (
    ##1 bias_voltage == {$past(bias[15]), $past(bias[14]), $past(bias[11]),
                         $past(bias[10]), $past(bias[5]), $past(bias[4])})
    else $error("Bias outputs do not match the bias register.");

  AST_BIAS_WRITE: assert property (
    commit && hit_bias && avs_byteenable == 4'hf
    |=> bias == ($past(wdata) & gpb_pkg::BIAS_MASK) ##1
        bias_voltage[3:2] == bias[11:10])
    else $error("Bias write not taken.");

  AST_RSVD_ZERO: assert property (
    !avs_waitrequest && $past(hit_bias) && $past(state) == gpb_pkg::ST_IDLE
    |-> (avs_readdata & ~32'(gpb_pkg::BIAS_MASK)) == 32'h0000_0000)
    else $error("Reserved bias bits read nonzero.");

  AST_ONE_WAIT: assert property (
    state == gpb_pkg::ST_IDLE && req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer timing wrong.");

  // Overrides only show when the override source and the stored output bit differ;
  // with equal values a wrong priority order would still pass.
  AST_STBY_WINS: assert property (
    misc[gpb_pkg::MISC_STBY] && ioctl.pin2_direction
    && standby_state != ioctl.pin2_out_value |=> pins.out[2] == $past(standby_state))
    else $error("Pin two output value beat the standby indicator.");

  AST_IRQ_WINS: assert property (
    ioctl.int_pin_sel == gpb_pkg::INT_SEL_PIN0 && ioctl.pin0_direction
    && irq_signal != ioctl.pin0_out_value |=> pins.out[0] == $past(irq_signal))
    else $error("Pin zero output value beat the interrupt routing.");

  // Outputs of a pin that is not driven sit at zero, so a released pin shows no stale data.
  AST_OFF_LOW: assert property (
    (pins.out & ~pins.oe) == 3'b000)
    else $error("Undriven pin shows a nonzero output value.");

  AST_BIAS_IN7: assert property (
    bias[gpb_pkg::BIAS_IN7] |=> bias_voltage[5])
    else $error("Bias on input seven not enabled.");

  AST_BIAS_IN6: assert property (
    bias[gpb_pkg::BIAS_IN6] |=> bias_voltage[4])
    else $error("Bias on input six not enabled.");

  AST_BIAS_IN5: assert property (
    bias[gpb_pkg::BIAS_IN5] |=> bias_voltage[3])
    else $error("Bias on input five not enabled.");

  AST_BIAS_IN4: assert property (
    bias[gpb_pkg::BIAS_IN4] |=> bias_voltage[2])
    else $error("Bias on input four not enabled.");

  AST_BIAS_IN3: assert property (
    bias[gpb_pkg::BIAS_IN3] |=> bias_voltage[1])
    else $error("Bias on input three not enabled.");

  AST_BIAS_IN2: assert property (
    bias[gpb_pkg::BIAS_IN2] |=> bias_voltage[0])
    else $error("Bias on input two not enabled.");

  // One clear bit must switch its own bias off whatever the other bits hold.
  AST_BIAS_OFF: assert property (
    !bias[gpb_pkg::BIAS_IN2] |=> !bias_voltage[0])
    else $error("Bias on input two left on with its bit clear.");

  AST_BIAS_RSVD: assert property (
    (bias & ~gpb_pkg::BIAS_MASK) == 16'h0000)
    else $error("Reserved bias position holds a one.");

  AST_IOCTL_RSVD: assert property (
    (ioctl & ~gpb_pkg::IOCTL_MASK) == 16'h0000)
    else $error("Unused pin control position holds a one.");

  AST_RD_UPPER: assert property (
    avs_readdata[gpb_pkg::DATA_W-1:gpb_pkg::REG_W] == 16'h0000)
    else $error("Upper half of read data is nonzero.");

  AST_IOCTL_WRITE: assert property (
    commit && hit_io && avs_byteenable[1:0] == 2'b11
    |=> ioctl == ($past(wdata) & gpb_pkg::IOCTL_MASK))
    else $error("Pin control write not taken.");

  AST_MISC_WRITE: assert property (
    commit && hit_misc && avs_byteenable[0]
    |=> misc[gpb_pkg::MISC_STBY] == $past(wdata[gpb_pkg::MISC_STBY]))
    else $error("Standby indicator enable write not taken.");

  // A lane that is not enabled keeps its old bits, so a byte write cannot clear its neighbour.
  AST_LANE_KEEP: assert property (
    commit && hit_bias && !avs_byteenable[0]
    |=> bias[gpb_pkg::REG_W/2-1:0] == $past(bias[gpb_pkg::REG_W/2-1:0]))
    else $error("Disabled byte lane of the bias register changed.");

  AST_UNMAPPED_WR: assert property (
    commit && !hit_io && !hit_bias && !hit_misc
    |=> $stable(ioctl) && $stable(bias) && $stable(misc))
    else $error("Write to an unmapped address changed a register.");

  AST_UNMAPPED_RD: assert property (
    state == gpb_pkg::ST_IDLE && req && !hit_io && !hit_bias && !hit_misc
    |=> avs_readdata == 32'h0000_0000)
    else $error("Read of an unmapped address returned nonzero data.");

  AST_WAIT_IDLE: assert property (
    state == gpb_pkg::ST_IDLE && !req |=> avs_waitrequest)
    else $error("Waitrequest dropped with no request.");

  // Read data stays put after the answer, so a late sampler still sees the last result.
  AST_RD_HOLD: assert property (
    state == gpb_pkg::ST_ACK |=> $stable(avs_readdata))
    else $error("Read data changed after the answer.");

  CV_RD_BIAS: cover property (state == gpb_pkg::ST_ACK && avs_read && hit_bias);
  CV_STBY: cover property (misc[gpb_pkg::MISC_STBY] && ioctl.pin2_direction);
  CV_IRQ: cover property (ioctl.int_pin_sel == gpb_pkg::INT_SEL_PIN0 && ioctl.pin0_direction);
  CV_BIAS: cover property (bias_voltage == 6'h3f);
  CV_ALL_OUT: cover property (pins.oe == 3'h7);
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic standby_state = 1'b0;
  logic irq_signal = 1'b0;
  gpb_pkg::gpb_pins_s pins;
  logic [5:0] bias_voltage;
  logic [31:0] pin_seen;
  logic probe = 1'b0;
  logic [31:0] rd_q[$];
  logic [11:0] pin_q[$];
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] seed;
  logic [15:0] ioc = 16'h0000;
  logic [15:0] bias = 16'h0000;
  logic stby = 1'b0;
  int bp[6] = '{4, 5, 10, 11, 14, 15};

  gpb_pin_ctrl u_gpb_pin_ctrl (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .standby_state(standby_state),
    .irq_signal(irq_signal), .pins(pins), .bias_voltage(bias_voltage));

  always #5 mclk = ~mclk;

  assign pin_seen = {20'h0_0000, pins.oe, pins.out, bias_voltage};

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // Overrides are applied last so they win over the direction bits.
  function automatic logic [11:0] exp_pins();
    logic [2:0] oe;
    logic [2:0] o;
    oe = ioc[3:1];
    o = ioc[7:5] & ioc[3:1];
    if (stby) begin
      oe[2] = 1'b1;
      o[2] = standby_state;
    end
    if (ioc[9:8] == 2'b10) begin
      oe[0] = 1'b1;
      o[0] = irq_signal;
    end
    return {oe, o, bias[15], bias[14], bias[11], bias[10], bias[5], bias[4]};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request stands until the rising edge that sees waitrequest low; the write lands there.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    {avs_address, avs_writedata, avs_byteenable, avs_read, avs_write} <= {a, d, be, !wr, wr};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    {avs_read, avs_write} <= 2'b00;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  task probe_pins();
    repeat (3) @(posedge mclk);
    pin_q.push_back(exp_pins());
    probe <= 1'b1;
    @(posedge mclk);
    probe <= 1'b0;
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0)
      check(avs_readdata, rd_q.pop_front());
    if (probe === 1'b1 && pin_q.size() > 0)
      check(pin_seen, {20'h0_0000, pin_q.pop_front()});
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h0000_899a;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    probe_pins();
    rd(8'h0c, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      bias = 16'h0001 << bp[i];
      bus(1'b1, 8'h10, {16'h0000, bias}, 4'hf);
      probe_pins();
    end
    bus(1'b1, 8'h10, 32'hffff_ffff, 4'h2);
    bias = 16'hcc00;
    rd(8'h10, 32'h0000_cc00);
    bus(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
    rd(8'h20, 32'h0000_0000);
    ioc = 16'h00ae;
    bus(1'b1, 8'h0c, {16'h0000, ioc}, 4'hf);
    probe_pins();
    ioc = 16'h0200;
    stby = 1'b1;
    bus(1'b1, 8'h0c, {16'h0000, ioc}, 4'hf);
    bus(1'b1, 8'h40, 32'h0000_0001, 4'hf);
    standby_state <= 1'b1;
    irq_signal <= 1'b1;
    probe_pins();
    standby_state <= 1'b0;
    irq_signal <= 1'b0;
    ioc = 16'h02aa;
    bus(1'b1, 8'h0c, {16'h0000, ioc}, 4'hf);
    probe_pins();
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      ioc = seed[15:0] & 16'h07ff;
      stby = seed[16];
      bus(1'b1, 8'h0c, seed, 4'hf);
      bus(1'b1, 8'h40, {31'h0000_0000, stby}, 4'hf);
      seed = lfsr(seed);
      bias = seed[15:0] & 16'hcc30;
      bus(1'b1, 8'h10, seed, 4'hf);
      standby_state <= seed[20];
      irq_signal <= seed[21];
      rd(8'h0c, {16'h0000, ioc});
      rd(8'h10, {16'h0000, bias});
      probe_pins();
    end
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    ioc = 16'h0000;
    bias = 16'h0000;
    stby = 1'b0;
    probe_pins();
    rd(8'h0c, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    print_verdict();
  end
endmodule
